/* hw/clock_control.sv */
/*
  Clock-control block with its serial configuration port: host clock output,
  slow clock output, timer clock select, RC calibration and read-only entries.
  Assumes all pins, serial clock included, are synchronous to i_mclk and the
  serial clock runs at no more than one sixth of i_mclk.
*/
`timescale 1ns/1ps
`include "clock_control_params.svh"
module clock_control #(
  parameter int CAL_CYCLES = `CAL_CYCLES,
  parameter logic [15:0] PART_ID = 16'h1234,
  parameter logic [7:0] REVISION_ID = 8'h0a
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_chip_en,
  input wire logic i_ref_osc_on,
  input wire logic i_ref_clk,
  input wire logic i_xtal32_clk,
  input wire logic i_rc_clk,
  input wire logic [9:0] i_log_signal_strength,
  input wire logic i_cfg_sel_n,
  input wire logic i_cfg_sclk,
  input wire logic i_cfg_sdi,
  output logic o_cfg_sdo,
  output logic o_cfg_sdo_oe,
  output logic o_host_clock_out,
  output logic o_slow_clk_out,
  output logic o_timer_clk,
  output logic o_xtal32_en,
  output logic o_rc_cal_busy,
  output clock_control_pkg::byte_t o_eng_tuning_3,
  output clock_control_pkg::byte_t o_eng_tuning_2,
  output clock_control_pkg::byte_t o_eng_tuning_1,
  output clock_control_pkg::byte_t o_eng_tuning_0
);
  import clock_control_pkg::*;

  byte_t clk_ctl;
  logic ce_q;
  logic reload;
  logic sclk_q;
  logic sclk_rise;
  logic sclk_fall;
  port_state_t state;
  logic [4:0] bit_cnt;
  logic [8:0] cmd_shift;
  byte_t wr_shift;
  byte_t rd_shift;
  logic is_read;
  byte_t addr;
  logic commit;
  logic [22:0] cal_cnt;
  logic cal_start;
  logic cal_bit_next;
  logic slow_live_en;
  logic slow_live_sel;
  logic slow_next_src;

  // Part and revision codes are arbitrary neutral values.
  function automatic byte_t read_value(input byte_t a);
    begin
      unique case (a)
        `OFS_CLK_CTL: read_value = clk_ctl;
        `OFS_SIG_HIGH: read_value = {6'h00, i_log_signal_strength[9:8]};
        `OFS_SIG_LOW: read_value = i_log_signal_strength[7:0];
        `OFS_ENG_3: read_value = o_eng_tuning_3;
        `OFS_ENG_2: read_value = o_eng_tuning_2;
        `OFS_ENG_1: read_value = o_eng_tuning_1;
        `OFS_ENG_0: read_value = o_eng_tuning_0;
        `OFS_PART_HIGH: read_value = PART_ID[15:8];
        `OFS_PART_LOW: read_value = PART_ID[7:0];
        `OFS_REVISION: read_value = REVISION_ID;
        default: read_value = 8'h00;
      endcase
    end
  endfunction

  assign reload = i_rst | (i_chip_en & ~ce_q);
  assign sclk_rise = i_cfg_sclk & ~sclk_q;
  assign sclk_fall = ~i_cfg_sclk & sclk_q;
  assign commit = state == PORT_DATA && sclk_rise && bit_cnt == `FRAME_BITS - 5'h1 && !is_read;
  assign cal_start = commit && addr == `OFS_CLK_CTL && wr_shift[6];
  // A write never leaves the calibration bit set without a run behind it.
  assign cal_bit_next = o_rc_cal_busy ? (cal_cnt != 23'h0) : wr_shift[6];
  assign o_cfg_sdo_oe = state == PORT_DATA && is_read;
  assign o_cfg_sdo = rd_shift[7];
  assign o_xtal32_en = clk_ctl[`BIT_XTAL_EN];

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ce_q <= 1'b0;
      sclk_q <= 1'b0;
    end else begin
      ce_q <= i_chip_en;
      sclk_q <= i_cfg_sclk;
    end
  end

  // Serial frame: read flag, eight address bits, eight data bits, MSB first.
  always_ff @(posedge i_mclk) begin
    if (i_rst || i_cfg_sel_n) begin
      state <= PORT_IDLE;
      bit_cnt <= 5'h00;
      cmd_shift <= 9'h000;
      wr_shift <= 8'h00;
      is_read <= 1'b0;
      addr <= 8'h00;
    end else begin
      unique case (state)
        PORT_IDLE: begin
          state <= PORT_CMD;
          bit_cnt <= 5'h00;
        end
        PORT_CMD: begin
          if (sclk_rise) begin
            cmd_shift <= {cmd_shift[7:0], i_cfg_sdi};
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == `CMD_BITS - 5'h1) begin
              state <= PORT_DATA;
              is_read <= cmd_shift[7];
              addr <= {cmd_shift[6:0], i_cfg_sdi};
            end
          end
        end
        PORT_DATA: begin
          if (sclk_rise) begin
            wr_shift <= {wr_shift[6:0], i_cfg_sdi};
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == `FRAME_BITS - 5'h1) begin
              state <= PORT_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Read data is latched when the address completes and shifts on falling edges.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rd_shift <= 8'h00;
    end else if (state == PORT_CMD && sclk_rise && bit_cnt == `CMD_BITS - 5'h1) begin
      rd_shift <= read_value({cmd_shift[6:0], i_cfg_sdi});
    end else if (o_cfg_sdo_oe && sclk_fall && bit_cnt != `CMD_BITS) begin
      rd_shift <= {rd_shift[6:0], 1'b0};
    end
  end

  // The calibration bit reads back as one until the run completes.
  always_ff @(posedge i_mclk) begin
    if (reload) begin
      clk_ctl <= `RST_CLK_CTL;
    end else if (commit && addr == `OFS_CLK_CTL) begin
      clk_ctl <= {cal_bit_next, wr_shift[5:0], i_cfg_sdi};
    end else if (o_rc_cal_busy && cal_cnt == 23'h0) begin
      clk_ctl[`BIT_CAL_EN] <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (reload) begin
      o_eng_tuning_3 <= `RST_ENG_3;
      o_eng_tuning_2 <= `RST_ENG_2;
      o_eng_tuning_1 <= `RST_ENG_1;
      o_eng_tuning_0 <= `RST_ENG_0;
    end else if (commit) begin
      unique case (addr)
        `OFS_ENG_3: o_eng_tuning_3 <= {wr_shift[6:0], i_cfg_sdi};
        `OFS_ENG_2: o_eng_tuning_2 <= {wr_shift[6:0], i_cfg_sdi};
        `OFS_ENG_1: o_eng_tuning_1 <= {wr_shift[6:0], i_cfg_sdi};
        `OFS_ENG_0: o_eng_tuning_0 <= {wr_shift[6:0], i_cfg_sdi};
        default: ;
      endcase
    end
  end

  // A start while a run is in progress does not restart it.
  always_ff @(posedge i_mclk) begin
    if (reload) begin
      o_rc_cal_busy <= 1'b0;
      cal_cnt <= 23'h0;
    end else if (cal_start && !o_rc_cal_busy) begin
      o_rc_cal_busy <= 1'b1;
      cal_cnt <= 23'(CAL_CYCLES - 1);
    end else if (o_rc_cal_busy) begin
      if (cal_cnt == 23'h0) begin
        o_rc_cal_busy <= 1'b0;
      end else begin
        cal_cnt <= cal_cnt - 23'h1;
      end
    end
  end

  host_clock_divider u_host_div (
    .i_mclk(i_mclk),
    .i_rst(reload | ~i_ref_osc_on),
    .i_ref_clk(i_ref_clk),
    .i_enable(clk_ctl[`BIT_HOST_EN] & i_ref_osc_on),
    .i_rate_sel(clk_ctl[`BIT_RATE_HI:`BIT_RATE_LO]),
    .o_clk(o_host_clock_out)
  );

  assign slow_next_src = clk_ctl[`BIT_SLOW_SEL] ? i_rc_clk : i_xtal32_clk;

  // The slow clock changes source only while output and new source are low.
  always_ff @(posedge i_mclk) begin
    if (reload) begin
      slow_live_en <= 1'b0;
      slow_live_sel <= 1'b0;
    end else if (!o_slow_clk_out && !slow_next_src) begin
      slow_live_en <= clk_ctl[`BIT_SLOW_EN];
      slow_live_sel <= clk_ctl[`BIT_SLOW_SEL];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (reload) begin
      o_slow_clk_out <= 1'b0;
      o_timer_clk <= 1'b0;
    end else begin
      o_slow_clk_out <= slow_live_en & (slow_live_sel ? i_rc_clk : i_xtal32_clk);
      o_timer_clk <= clk_ctl[`BIT_TIMER_SEL] ? i_rc_clk : i_xtal32_clk;
    end
  end

  property p_cal_start;
    @(posedge i_mclk) disable iff (reload)
      cal_start && !o_rc_cal_busy |=> o_rc_cal_busy && cal_cnt == 23'(CAL_CYCLES - 1);
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("calibration did not start");

  property p_cal_hold;
    @(posedge i_mclk) disable iff (reload)
      o_rc_cal_busy && cal_cnt != 23'h0 |=> o_rc_cal_busy && clk_ctl[`BIT_CAL_EN];
  endproperty
  a_cal_hold: assert property (p_cal_hold) else $error("calibration ended early");

  property p_cal_end;
    @(posedge i_mclk) disable iff (reload)
      o_rc_cal_busy && cal_cnt == 23'h0 |=> !o_rc_cal_busy && !clk_ctl[`BIT_CAL_EN];
  endproperty
  a_cal_end: assert property (p_cal_end) else $error("calibration did not end");

  property p_slow_off;
    @(posedge i_mclk) disable iff (reload) !slow_live_en |=> !o_slow_clk_out;
  endproperty
  a_slow_off: assert property (p_slow_off) else $error("slow clock not low");

  property p_xtal_write;
    @(posedge i_mclk) disable iff (reload)
      commit && addr == `OFS_CLK_CTL |=> o_xtal32_en == $past(i_cfg_sdi);
  endproperty
  a_xtal_write: assert property (p_xtal_write) else $error("crystal enable not written");

  property p_reload;
    @(posedge i_mclk) reload |=> clk_ctl == `RST_CLK_CTL && o_eng_tuning_0 == `RST_ENG_0
      && !o_rc_cal_busy;
  endproperty
  a_reload: assert property (p_reload) else $error("defaults not loaded");

  property p_sig_read;
    @(posedge i_mclk) disable iff (reload)
      state == PORT_CMD && sclk_rise && bit_cnt == `CMD_BITS - 5'h1
      && {cmd_shift[6:0], i_cfg_sdi} == `OFS_SIG_LOW
      |=> rd_shift == $past(i_log_signal_strength[7:0]);
  endproperty
  a_sig_read: assert property (p_sig_read) else $error("signal strength read wrong");

  property p_eng_write;
    @(posedge i_mclk) disable iff (reload)
      commit && addr == `OFS_ENG_2 |=> o_eng_tuning_2 == $past({wr_shift[6:0], i_cfg_sdi});
  endproperty
  a_eng_write: assert property (p_eng_write) else $error("tuning write lost");

  property p_timer_sel;
    @(posedge i_mclk) disable iff (reload)
      clk_ctl[`BIT_TIMER_SEL] && $stable(clk_ctl) ##1 $stable(clk_ctl)
      |-> o_timer_clk == $past(i_rc_clk);
  endproperty
  a_timer_sel: assert property (p_timer_sel) else $error("timer source wrong");

  property p_sleep_low;
    @(posedge i_mclk) disable iff (reload) !i_ref_osc_on |=> !o_host_clock_out;
  endproperty
  a_sleep_low: assert property (p_sleep_low) else $error("host clock runs in sleep");

  property p_cal_bit_busy;
    @(posedge i_mclk) disable iff (reload) o_rc_cal_busy |-> clk_ctl[`BIT_CAL_EN];
  endproperty
  a_cal_bit_busy: assert property (p_cal_bit_busy) else $error("calibration bit low in run");

  property p_cal_bit_start;
    @(posedge i_mclk) disable iff (reload)
      commit && addr == `OFS_CLK_CTL && wr_shift[6] && !o_rc_cal_busy |=> o_rc_cal_busy;
  endproperty
  a_cal_bit_start: assert property (p_cal_bit_start) else $error("calibration bit ignored");

  property p_timer_xtal;
    @(posedge i_mclk) disable iff (reload)
      !clk_ctl[`BIT_TIMER_SEL] && $stable(clk_ctl) ##1 $stable(clk_ctl)
      |-> o_timer_clk == $past(i_xtal32_clk);
  endproperty
  a_timer_xtal: assert property (p_timer_xtal) else $error("timer crystal source wrong");

  property p_sig_high;
    @(posedge i_mclk) disable iff (reload)
      state == PORT_CMD && sclk_rise && bit_cnt == `CMD_BITS - 5'h1
      && {cmd_shift[6:0], i_cfg_sdi} == `OFS_SIG_HIGH
      |=> rd_shift == {6'h00, $past(i_log_signal_strength[9:8])};
  endproperty
  a_sig_high: assert property (p_sig_high) else $error("signal strength high read wrong");

  property p_part_read;
    @(posedge i_mclk) disable iff (reload)
      state == PORT_CMD && sclk_rise && bit_cnt == `CMD_BITS - 5'h1
      && {cmd_shift[6:0], i_cfg_sdi} == `OFS_PART_HIGH
      |=> rd_shift == PART_ID[15:8];
  endproperty
  a_part_read: assert property (p_part_read) else $error("part identifier read wrong");

  property p_sdo_shift;
    @(posedge i_mclk) disable iff (reload)
      o_cfg_sdo_oe && sclk_fall && bit_cnt != `CMD_BITS |=> o_cfg_sdo == $past(rd_shift[6]);
  endproperty
  a_sdo_shift: assert property (p_sdo_shift) else $error("read data did not advance");

  c_cal_done: cover property (@(posedge i_mclk) o_rc_cal_busy ##1 !o_rc_cal_busy);
  c_read: cover property (@(posedge i_mclk) o_cfg_sdo_oe ##1 state == PORT_IDLE);
  c_write: cover property (@(posedge i_mclk) commit && addr == `OFS_CLK_CTL);
  c_host_clk: cover property (@(posedge i_mclk) $rose(o_host_clock_out));
  c_sleep: cover property (@(posedge i_mclk) !i_ref_osc_on && clk_ctl[`BIT_HOST_EN]);
endmodule // clock_control

/* hw/clock_control_params.svh */
/*
  Holds the register map, field positions, reset values and timing counts of
  the clock-control block. Assumes a 250 MHz system clock.
*/
`ifndef CLOCK_CONTROL_PARAMS_SVH
`define CLOCK_CONTROL_PARAMS_SVH

`define OFS_CLK_CTL 8'h00
`define OFS_SIG_HIGH 8'hb4
`define OFS_SIG_LOW 8'hb5
`define OFS_ENG_3 8'he1
`define OFS_ENG_2 8'he2
`define OFS_ENG_1 8'he3
`define OFS_ENG_0 8'he4
`define OFS_PART_HIGH 8'hfd
`define OFS_PART_LOW 8'hfe
`define OFS_REVISION 8'hff

`define BIT_CAL_EN 7
`define BIT_HOST_EN 6
`define BIT_SLOW_EN 5
`define BIT_RATE_HI 4
`define BIT_RATE_LO 3
`define BIT_SLOW_SEL 2
`define BIT_TIMER_SEL 1
`define BIT_XTAL_EN 0

`define RST_CLK_CTL 8'h00
`define RST_ENG_3 8'h80
`define RST_ENG_2 8'h20
`define RST_ENG_1 8'h19
`define RST_ENG_0 8'h51

`define CMD_BITS 5'h09
`define FRAME_BITS 5'h11

`define CAL_TIME_MS 20
`define MCLK_KHZ 250000
`define CAL_CYCLES (`CAL_TIME_MS * `MCLK_KHZ)

`endif

/* hw/clock_control_pkg.sv */
/*
  Holds the shared types of the clock-control block. Assumes nothing else.
*/
package clock_control_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [1:0] rate_t;
  typedef enum logic [1:0] {
    PORT_IDLE = 2'b00,
    PORT_CMD = 2'b01,
    PORT_DATA = 2'b11
  } port_state_t;
endpackage

/* hw/host_clock_divider.sv */
/*
  Divides a sampled 16 MHz reference into 1, 2, 4 or 8 MHz without glitches.
  Assumes the reference level is synchronous to i_mclk.
*/
`timescale 1ns/1ps
module host_clock_divider (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ref_clk,
  input wire logic i_enable,
  input wire clock_control_pkg::rate_t i_rate_sel,
  output logic o_clk
);
  import clock_control_pkg::*;

  logic ref_q;
  logic [3:0] cnt;
  logic live_en;
  rate_t live_sel;
  logic ref_rise;

  assign ref_rise = i_ref_clk & ~ref_q;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ref_q <= 1'b0;
      cnt <= 4'h0;
    end else begin
      ref_q <= i_ref_clk;
      if (ref_rise) begin
        cnt <= cnt + 4'h1;
      end
    end
  end

  // Settings change only at the wrap, where every tap goes low together.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      live_en <= 1'b0;
      live_sel <= 2'b00;
    end else if (ref_rise && cnt == 4'hf) begin
      live_en <= i_enable;
      live_sel <= i_rate_sel;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_clk <= 1'b0;
    end else begin
      o_clk <= live_en & cnt[2'd3 - live_sel];
    end
  end

  property p_idle_low;
    @(posedge i_mclk) disable iff (i_rst) !live_en |=> !o_clk;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("host clock not low");

  property p_switch_wrap;
    @(posedge i_mclk) disable iff (i_rst) $changed(live_sel) |-> cnt == 4'h0;
  endproperty
  a_switch_wrap: assert property (p_switch_wrap) else $error("rate switched mid-cycle");
endmodule // host_clock_divider

/* verif/clock_source_model.sv */
/*
  Model of the oscillators around the block: 16 MHz reference, 32 kHz crystal
  and on-chip RC clock, all scaled to whole i_mclk cycles.
  Assumes i_mclk and a synchronous active-high i_rst from the bench.
*/
`timescale 1ns/1ps
module clock_source_model #(
  parameter int REF_HALF = 8,
  parameter int XTAL_HALF = 20,
  parameter int RC_HALF = 50
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ref_on,
  input wire logic i_xtal_on,
  output logic o_ref_clk,
  output logic o_xtal32_clk,
  output logic o_rc_clk
);
  int ref_cnt;
  int xtal_cnt;
  int rc_cnt;

  // The reference runs only while the host keeps it enabled.
  always_ff @(posedge i_mclk) begin
    if (i_rst || !i_ref_on) begin
      ref_cnt <= 0;
      o_ref_clk <= 1'b0;
    end else if (ref_cnt == REF_HALF - 1) begin
      ref_cnt <= 0;
      o_ref_clk <= ~o_ref_clk;
    end else begin
      ref_cnt <= ref_cnt + 1;
    end
  end

  // The watch crystal stands low while its oscillator is switched off.
  always_ff @(posedge i_mclk) begin
    if (i_rst || !i_xtal_on) begin
      xtal_cnt <= 0;
      o_xtal32_clk <= 1'b0;
    end else if (xtal_cnt == XTAL_HALF - 1) begin
      xtal_cnt <= 0;
      o_xtal32_clk <= ~o_xtal32_clk;
    end else begin
      xtal_cnt <= xtal_cnt + 1;
    end
  end

  // The RC oscillator runs free.
  always_ff @(posedge i_mclk) begin
    if (i_rst || rc_cnt == RC_HALF - 1) begin
      rc_cnt <= 0;
      o_rc_clk <= i_rst ? 1'b0 : ~o_rc_clk;
    end else begin
      rc_cnt <= rc_cnt + 1;
    end
  end
endmodule // clock_source_model

/* verif/testbench.sv */
/*
  Self-checking bench of the clock-control block over its serial port.
  Assumes the oscillator model beside it and a short calibration count.
*/
`timescale 1ns/1ps
`include "clock_control_params.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; $display("Error %s expected %h seen %h", nm, e, g); end end
module testbench;
  import clock_control_pkg::*;
  localparam int CAL = 20;
  localparam logic [15:0] PID = 16'h5a3c; // Arbitrary value.
  localparam logic [7:0] RID = 8'h07; // Arbitrary value.
  localparam byte_t eng_ofs [4] = '{`OFS_ENG_3, `OFS_ENG_2, `OFS_ENG_1, `OFS_ENG_0};
  localparam byte_t eng_rst [4] = '{`RST_ENG_3, `RST_ENG_2, `RST_ENG_1, `RST_ENG_0};
  logic i_mclk = 0, i_rst = 1, i_chip_en = 1, i_ref_osc_on = 1;
  logic i_cfg_sel_n = 1, i_cfg_sclk = 0, i_cfg_sdi = 0;
  logic [9:0] i_log_signal_strength = 10'h000;
  logic ref_clk, xtal_clk, rc_clk, sdo, host_clk, slow_clk, timer_clk, xtal_en, cal_busy, oe;
  byte_t eng3, eng2, eng1, eng0;
  int n_errors = 0, checks_done = 0, busy_len = 0, busy_run = 0;

  always #2 i_mclk = ~i_mclk;

  clock_source_model u_src (.i_mclk(i_mclk), .i_rst(i_rst), .i_ref_on(i_ref_osc_on),
    .i_xtal_on(xtal_en), .o_ref_clk(ref_clk), .o_xtal32_clk(xtal_clk), .o_rc_clk(rc_clk));

  clock_control #(.CAL_CYCLES(CAL), .PART_ID(PID), .REVISION_ID(RID)) u_dut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_chip_en(i_chip_en), .i_ref_osc_on(i_ref_osc_on),
    .i_ref_clk(ref_clk), .i_xtal32_clk(xtal_clk), .i_rc_clk(rc_clk),
    .i_log_signal_strength(i_log_signal_strength), .i_cfg_sel_n(i_cfg_sel_n),
    .i_cfg_sclk(i_cfg_sclk), .i_cfg_sdi(i_cfg_sdi), .o_cfg_sdo(sdo), .o_cfg_sdo_oe(oe),
    .o_host_clock_out(host_clk), .o_slow_clk_out(slow_clk), .o_timer_clk(timer_clk),
    .o_xtal32_en(xtal_en), .o_rc_cal_busy(cal_busy), .o_eng_tuning_3(eng3),
    .o_eng_tuning_2(eng2), .o_eng_tuning_1(eng1), .o_eng_tuning_0(eng0));

  // Length of the last calibration busy pulse, in cycles.
  always @(posedge i_mclk) begin
    if (cal_busy === 1'b1) begin
      busy_run <= busy_run + 1;
    end else if (busy_run != 0) begin
      busy_len <= busy_run;
      busy_run <= 0;
    end
  end

  task automatic stop_test;
    if (n_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  // One serial frame; fewer than 17 bits aborts it by deselecting.
  task automatic xfer(input logic rd_flag, input byte_t addr, input byte_t wdata,
                      input int nbits, output byte_t rdata);
    logic [16:0] frame;
    frame = {rd_flag, addr, wdata};
    rdata = 8'h00;
    i_cfg_sel_n = 0;
    for (int i = 16; i > 16 - nbits; i--) begin
      i_cfg_sdi = frame[i];
      cyc(3);
      if (i < 8) begin
        rdata = {rdata[6:0], sdo};
        `CHK("sdo_oe", rd_flag, oe)
      end
      i_cfg_sclk = 1;
      cyc(3);
      i_cfg_sclk = 0;
    end
    cyc(3);
    i_cfg_sel_n = 1;
    cyc(3);
  endtask

  task automatic wr(input byte_t a, input byte_t d);
    byte_t t;
    xfer(1'b0, a, d, 17, t);
  endtask

  task automatic rdchk(input byte_t a, input byte_t e, input string nm);
    byte_t t;
    xfer(1'b1, a, 8'h00, 17, t);
    `CHK(nm, e, t)
  endtask

  // Counts rises of host (0), slow (1) or timer (2) clock over 2048 cycles.
  task automatic rate_chk(input int sel, input int exp, input string nm);
    logic prev, cur;
    int n;
    cyc(600);
    n = 0;
    prev = 1'b0;
    repeat (2048) begin
      cyc(1);
      cur = (sel == 0) ? host_clk : (sel == 1) ? slow_clk : timer_clk;
      if (cur === 1'b1 && prev === 1'b0) n++;
      prev = cur;
    end
    `CHK(nm, 1'b1, (n >= exp - (exp > 0) && n <= exp + (exp > 0)))
  endtask

  initial begin
    cyc(20);
    i_rst = 0;
    cyc(2);
    rdchk(`OFS_CLK_CTL, `RST_CLK_CTL, "ctl_reset");
    `CHK("eng_out", {`RST_ENG_3, `RST_ENG_0}, {eng3, eng0})
    `CHK("eng_mid", {`RST_ENG_2, `RST_ENG_1}, {eng2, eng1})
    for (int k = 0; k < 4; k++) begin
      wr(eng_ofs[k], eng_rst[k]);
      rdchk(eng_ofs[k], eng_rst[k], "eng_reg");
    end
    rdchk(`OFS_PART_HIGH, PID[15:8], "part_high");
    rdchk(`OFS_PART_LOW, PID[7:0], "part_low");
    rdchk(`OFS_REVISION, RID, "revision");
    i_log_signal_strength = 10'h2b6;
    rdchk(`OFS_SIG_HIGH, 8'h02, "sig_high");
    rdchk(`OFS_SIG_LOW, 8'hb6, "sig_low");
    wr(`OFS_PART_HIGH, 8'h00);
    rdchk(`OFS_PART_HIGH, PID[15:8], "ro_write");
    rdchk(8'h80, 8'h00, "unmapped");
    for (int c = 0; c < 4; c++) begin
      wr(`OFS_CLK_CTL, {3'b010, c[1:0], 3'b001});
      rdchk(`OFS_CLK_CTL, {3'b010, c[1:0], 3'b001}, "ctl_rw");
      rate_chk(0, 8 << c, "host_rate");
    end
    wr(`OFS_CLK_CTL, 8'h19);
    rate_chk(0, 0, "host_off");
    wr(`OFS_CLK_CTL, 8'h41);
    i_ref_osc_on = 0;
    rate_chk(0, 0, "host_sleep");
    `CHK("host_low", 1'b0, host_clk)
    i_ref_osc_on = 1;
    wr(`OFS_CLK_CTL, 8'h21);
    rate_chk(1, 51, "slow_xtal");
    wr(`OFS_CLK_CTL, 8'h25);
    rate_chk(1, 20, "slow_rc");
    wr(`OFS_CLK_CTL, 8'h20);
    `CHK("xtal_en", 1'b0, xtal_en)
    rate_chk(1, 0, "xtal_stopped");
    wr(`OFS_CLK_CTL, 8'h01);
    `CHK("xtal_on", 1'b1, xtal_en)
    rate_chk(1, 0, "slow_off");
    rate_chk(2, 51, "timer_xtal");
    wr(`OFS_CLK_CTL, 8'h03);
    rate_chk(2, 20, "timer_rc");
    // The reference stays enabled for the whole calibration run.
    wr(`OFS_CLK_CTL, 8'h83);
    for (int w = 0; w < 200 && busy_len == 0; w++) cyc(1);
    `CHK("cal_len", CAL, busy_len)
    rdchk(`OFS_CLK_CTL, 8'h03, "cal_clear");
    wr(`OFS_CLK_CTL, 8'h61);
    i_chip_en = 0;
    cyc(2);
    i_chip_en = 1;
    cyc(2);
    rdchk(`OFS_CLK_CTL, `RST_CLK_CTL, "chip_en_ctl");
    `CHK("chip_en_out", {`RST_ENG_3, 1'b0}, {eng3, xtal_en})
    stop_test();
  end
endmodule // testbench
